// ==== rtl/vlu_map.vh ====
/*
 Register map, field layout and opcode codes of the vector logical unit.
 Assumes inclusion by the unit's design file and the bench files; definitions only.
*/
`ifndef VLU_MAP_VH
`define VLU_MAP_VH

// Byte offsets on the AXI4-Lite register bus
`define VLU_OFS_INSTR    8'h00
`define VLU_OFS_STATUS   8'h04
`define VLU_OFS_COUNT    8'h08
`define VLU_OFS_MASK_LO  8'h0c
`define VLU_OFS_MASK_HI  8'h10
`define VLU_OFS_SCAL_LO  8'h14
`define VLU_OFS_SCAL_HI  8'h18
`define VLU_OFS_VADDR    8'h1c
`define VLU_OFS_VDATA_LO 8'h20
`define VLU_OFS_VDATA_HI 8'h24

// Instruction word fields: operation code, then i, j, k designators
`define VLU_F_OP   15:9
`define VLU_F_I    8:6
`define VLU_F_J    5:3
`define VLU_F_K    2:0

// Status bits
`define VLU_ST_BUSY    0
`define VLU_ST_BADOP   1
`define VLU_ST_OVERRUN 2

// Vector access address fields
`define VLU_VA_REG  8:6
`define VLU_VA_ELEM 5:0

// Operation codes, octal 140 through 147
`define VLU_OP_AND_S 7'h60
`define VLU_OP_AND_V 7'h61
`define VLU_OP_OR_S  7'h62
`define VLU_OP_OR_V  7'h63
`define VLU_OP_XOR_S 7'h64
`define VLU_OP_XOR_V 7'h65
`define VLU_OP_MRG_S 7'h66
`define VLU_OP_MRG_V 7'h67

// Reset values and AXI responses
`define VLU_RST_COUNT 7'h00
`define VLU_RESP_OK   2'h0
`define VLU_RESP_ERR  2'h2

`endif

// ==== rtl/vlu_top.v ====
/*
 Vector logical unit with its own eight-register vector file, an
 AXI4-Lite slave for control, operands and vector access, and a
 two-entry result buffer in front of the vector file write port.
 Assumes one clock, synchronous active-low reset, and a bus master
 that keeps at most one read and one write under way.
*/
// Overview of operation
// [RL1] Scalar AND each source element into destination
// [RL2] Scalar AND with j zero writes zeros
// [RL3] Process element count elements from element zero
// [RL4] Vector AND; equal sources copy unchanged
// [RL5] Scalar OR; j zero copies source
// [RL6] Vector OR; equal sources copy first source
// [RL7] Scalar difference; j zero copies source
// [RL8] Vector difference; equal sources clear elements
// [RL9] Scalar merge: mask one picks scalar
// [RL10] Scalar merge with j zero: mask one zeroes
// [RL11] Vector merge: mask one picks first source
// [RL12] Only opcodes 140 to 147 execute here
// [RL13] Logical difference is 64-bit exclusive OR
// [RL14] Seven-bit opcode then i, j, k designators
// [RL15] Elements past element count stay unaltered
`include "vlu_map.vh"

module vlu_top #(
   parameter NELEM = 64,
   parameter AW    = 8
) (
   input  wire          clk_sys,
   input  wire          rst_b,
   input  wire [AW-1:0] s_axi_awaddr,
   input  wire          s_axi_awvalid,
   output wire          s_axi_awready,
   input  wire [31:0]   s_axi_wdata,
   input  wire [3:0]    s_axi_wstrb,
   input  wire          s_axi_wvalid,
   output wire          s_axi_wready,
   output reg  [1:0]    s_axi_bresp,
   output reg           s_axi_bvalid,
   input  wire          s_axi_bready,
   input  wire [AW-1:0] s_axi_araddr,
   input  wire          s_axi_arvalid,
   output wire          s_axi_arready,
   output reg  [31:0]   s_axi_rdata,
   output reg  [1:0]    s_axi_rresp,
   output reg           s_axi_rvalid,
   input  wire          s_axi_rready
);

   localparam BUF_W  = 73;
   localparam ST_IDL = 2'h0;
   localparam ST_RUN = 2'h1;
   localparam ST_DRN = 2'h2;

   // Byte-lane merge of a 32-bit write into an old word
   function [31:0] vlu_merge;
      input [31:0] old_v;
      input [31:0] new_v;
      input [3:0]  strb;
      integer      b;
      begin
         vlu_merge = old_v;
         for (b = 0; b < 4; b = b + 1) begin
            if (strb[b])
               vlu_merge[b*8 +: 8] = new_v[b*8 +: 8];
         end
      end
   endfunction

   // Register decode shared by the read and write paths
   function vlu_mapped;
      input [AW-1:0] a;
      begin
         case (a)
            `VLU_OFS_INSTR, `VLU_OFS_STATUS, `VLU_OFS_COUNT,
            `VLU_OFS_MASK_LO, `VLU_OFS_MASK_HI, `VLU_OFS_SCAL_LO,
            `VLU_OFS_SCAL_HI, `VLU_OFS_VADDR, `VLU_OFS_VDATA_LO,
            `VLU_OFS_VDATA_HI: vlu_mapped = 1'b1;
            default:           vlu_mapped = 1'b0;
         endcase
      end
   endfunction

   // One element of the selected logical or merge operation
   function [63:0] vlu_alu;
      input [6:0]  op;
      input [63:0] s;
      input [63:0] a;
      input [63:0] b;
      input        m;
      begin
         case (op)
            `VLU_OP_AND_S: vlu_alu = s & b;        // RL1
            `VLU_OP_AND_V: vlu_alu = a & b;        // RL4
            `VLU_OP_OR_S:  vlu_alu = s | b;        // RL5
            `VLU_OP_OR_V:  vlu_alu = a | b;        // RL6
            `VLU_OP_XOR_S: vlu_alu = s ^ b;        // RL7 RL13
            `VLU_OP_XOR_V: vlu_alu = a ^ b;        // RL8 RL13
            `VLU_OP_MRG_S: vlu_alu = m ? s : b;    // RL9
            `VLU_OP_MRG_V: vlu_alu = m ? a : b;    // RL11
            default:       vlu_alu = b;
         endcase
      end
   endfunction

   // Vector file: eight registers of NELEM 64-bit elements
   reg  [63:0]    vreg [0:8*NELEM-1];

   reg  [AW-1:0]  aw_addr_q;
   reg            aw_held_q;
   reg  [31:0]    w_data_q;
   reg  [3:0]     w_strb_q;
   reg            w_held_q;
   reg  [15:0]    instr_q;
   reg  [6:0]     count_q;
   reg  [63:0]    mask_q;
   reg  [63:0]    scal_q;
   reg  [8:0]     vaddr_q;
   reg            badop_q;
   reg            overrun_q;
   reg  [1:0]     state_q;
   reg  [5:0]     idx_q;
   reg  [BUF_W-1:0] ent0_q;
   reg  [BUF_W-1:0] ent1_q;
   reg  [1:0]     cnt_q;

   wire           do_write;
   wire           wr_ok;
   wire           ar_fire;
   wire           sw_vec_wr;
   wire           busy;
   wire [6:0]     op;
   wire [2:0]     fi;
   wire [2:0]     fj;
   wire [2:0]     fk;
   wire [63:0]    s_opnd;
   wire [63:0]    a_opnd;
   wire [63:0]    b_opnd;
   wire [63:0]    result;
   wire           buf_in_valid;
   wire           buf_in_ready;
   wire           buf_out_valid;
   wire           buf_out_ready;
   wire           push;
   wire           pop;
   wire           last_elem;
   wire           start_req;
   wire           op_legal;
   wire [63:0]    vsel;
   wire [31:0]    cnt_wr;
   wire [31:0]    vaddr_wr;

   // Write channel: address and data taken in either order
   assign s_axi_awready = ~aw_held_q;
   assign s_axi_wready  = ~w_held_q;
   assign do_write      = aw_held_q & w_held_q & ~s_axi_bvalid;
   assign wr_ok         = vlu_mapped(aw_addr_q);
   assign ar_fire       = s_axi_arvalid & s_axi_arready;
   assign s_axi_arready = ~s_axi_rvalid;

   assign sw_vec_wr = do_write & ((aw_addr_q == `VLU_OFS_VDATA_LO) |
                                  (aw_addr_q == `VLU_OFS_VDATA_HI));
   assign start_req = do_write & (aw_addr_q == `VLU_OFS_INSTR);
   assign vsel      = vreg[vaddr_q];
   // Strobe-merged write values of the narrow registers, cut to width below
   assign cnt_wr    = vlu_merge({25'h0, count_q}, w_data_q, w_strb_q);
   assign vaddr_wr  = vlu_merge({23'h0, vaddr_q}, w_data_q, w_strb_q);

   // Instruction fields
   assign op = instr_q[`VLU_F_OP];                             // RL14
   assign fi = instr_q[`VLU_F_I];                              // RL14
   assign fj = instr_q[`VLU_F_J];                              // RL14
   assign fk = instr_q[`VLU_F_K];                              // RL14
   assign op_legal = (w_data_q[`VLU_F_OP] >= `VLU_OP_AND_S) &
                     (w_data_q[`VLU_F_OP] <= `VLU_OP_MRG_V); // RL12

   // j of zero stands for a zero scalar, which yields the j-zero special forms of RL2, RL5, RL7 and RL10
   assign s_opnd = (fj == 3'h0) ? 64'h0 : scal_q;    // RL2
   assign a_opnd = vreg[{fj, idx_q}];
   assign b_opnd = vreg[{fk, idx_q}];
   assign result = vlu_alu(op, s_opnd, a_opnd, b_opnd, mask_q[idx_q]); // RL10

   // Two-entry result buffer; the vector file stalls it on software writes
   assign buf_in_valid  = (state_q == ST_RUN);
   assign buf_in_ready  = (cnt_q != 2'h2);
   assign buf_out_valid = (cnt_q != 2'h0);
   assign buf_out_ready = ~sw_vec_wr;
   assign push = buf_in_valid & buf_in_ready;
   assign pop  = buf_out_valid & buf_out_ready;
   assign last_elem = ({1'b0, idx_q} == (count_q - 7'h01));
   assign busy = (state_q != ST_IDL) | buf_out_valid;

   // AXI write side holding registers and response
   always @(posedge clk_sys) begin
      if (!rst_b) begin
         aw_addr_q    <= {AW{1'b0}};
         aw_held_q    <= 1'b0;
         w_data_q     <= 32'h0;
         w_strb_q     <= 4'h0;
         w_held_q     <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= `VLU_RESP_OK;
      end else begin
         if (s_axi_awvalid & ~aw_held_q) begin
            aw_addr_q <= s_axi_awaddr;
            aw_held_q <= 1'b1;
         end
         if (s_axi_wvalid & ~w_held_q) begin
            w_data_q <= s_axi_wdata;
            w_strb_q <= s_axi_wstrb;
            w_held_q <= 1'b1;
         end
         if (do_write) begin
            aw_held_q    <= 1'b0;
            w_held_q     <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_ok ? `VLU_RESP_OK : `VLU_RESP_ERR;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // Software-written control and operand registers
   always @(posedge clk_sys) begin
      if (!rst_b) begin
         count_q   <= `VLU_RST_COUNT;
         mask_q    <= 64'h0;
         scal_q    <= 64'h0;
         vaddr_q   <= 9'h000;
         badop_q   <= 1'b0;
         overrun_q <= 1'b0;
      end else begin
         if (do_write) begin
            case (aw_addr_q)
               `VLU_OFS_COUNT:
                  count_q <= (cnt_wr > NELEM) ? NELEM[6:0] : cnt_wr[6:0];
               `VLU_OFS_MASK_LO: mask_q[31:0]  <= vlu_merge(mask_q[31:0], w_data_q, w_strb_q);
               `VLU_OFS_MASK_HI: mask_q[63:32] <= vlu_merge(mask_q[63:32], w_data_q, w_strb_q);
               `VLU_OFS_SCAL_LO: scal_q[31:0]  <= vlu_merge(scal_q[31:0], w_data_q, w_strb_q);
               `VLU_OFS_SCAL_HI: scal_q[63:32] <= vlu_merge(scal_q[63:32], w_data_q, w_strb_q);
               `VLU_OFS_VADDR:
                  vaddr_q <= vaddr_wr[8:0];
               default: ;
            endcase
         end
         // Sticky errors: a new event in the clearing cycle wins
         if (start_req & ~busy & ~op_legal)
            badop_q <= 1'b1;                                         // RL12
         else if (do_write & (aw_addr_q == `VLU_OFS_STATUS) & w_data_q[`VLU_ST_BADOP])
            badop_q <= 1'b0;
         if (start_req & busy)
            overrun_q <= 1'b1;
         else if (do_write & (aw_addr_q == `VLU_OFS_STATUS) & w_data_q[`VLU_ST_OVERRUN])
            overrun_q <= 1'b0;
      end
   end

   // Issue and element sequencer
   always @(posedge clk_sys) begin
      if (!rst_b) begin
         state_q <= ST_IDL;
         instr_q <= 16'h0000;
         idx_q   <= 6'h00;
      end else begin
         case (state_q)
            ST_IDL: begin
               // Instructions arriving while busy are refused, not queued
               if (start_req & op_legal) begin
                  instr_q <= w_data_q[15:0];
                  idx_q   <= 6'h00;                              // RL3
                  state_q <= (count_q == 7'h00) ? ST_IDL : ST_RUN;
               end
            end
            ST_RUN: begin
               if (push) begin
                  if (last_elem)
                     state_q <= ST_DRN;                           // RL3
                  else
                     idx_q <= idx_q + 6'h01;
               end
            end
            ST_DRN: begin
               if (~buf_out_valid)
                  state_q <= ST_IDL;
            end
            default: state_q <= ST_IDL;
         endcase
      end
   end

   // Buffer storage: entry holds destination address and result
   always @(posedge clk_sys) begin
      if (!rst_b) begin
         cnt_q  <= 2'h0;
         ent0_q <= {BUF_W{1'b0}};
         ent1_q <= {BUF_W{1'b0}};
      end else begin
         if (push & pop) begin
            if (cnt_q == 2'h1) begin
               ent0_q <= {fi, idx_q, result};
            end else begin
               ent0_q <= ent1_q;
               ent1_q <= {fi, idx_q, result};
            end
         end else if (pop) begin
            ent0_q <= ent1_q;
            cnt_q  <= cnt_q - 2'h1;
         end else if (push) begin
            if (cnt_q == 2'h0)
               ent0_q <= {fi, idx_q, result};
            else
               ent1_q <= {fi, idx_q, result};
            cnt_q <= cnt_q + 2'h1;
         end
      end
   end

   // Vector file write port; software writes take priority over buffered results
   always @(posedge clk_sys) begin
      if (sw_vec_wr) begin
         if (aw_addr_q == `VLU_OFS_VDATA_LO)
            vreg[vaddr_q] <= {vsel[63:32], vlu_merge(vsel[31:0], w_data_q, w_strb_q)};
         else
            vreg[vaddr_q] <= {vlu_merge(vsel[63:32], w_data_q, w_strb_q), vsel[31:0]};
      end else if (pop) begin
         vreg[ent0_q[72:64]] <= ent0_q[63:0];                     // RL15
      end
   end

   // Read channel: data registered one cycle after the address is taken
   always @(posedge clk_sys) begin
      if (!rst_b) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0;
         s_axi_rresp  <= `VLU_RESP_OK;
      end else if (ar_fire) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp  <= vlu_mapped(s_axi_araddr) ? `VLU_RESP_OK : `VLU_RESP_ERR;
         case (s_axi_araddr)
            `VLU_OFS_INSTR:    s_axi_rdata <= {16'h0, instr_q};
            `VLU_OFS_STATUS:   s_axi_rdata <= {29'h0, overrun_q, badop_q, busy};
            `VLU_OFS_COUNT:    s_axi_rdata <= {25'h0, count_q};
            `VLU_OFS_MASK_LO:  s_axi_rdata <= mask_q[31:0];
            `VLU_OFS_MASK_HI:  s_axi_rdata <= mask_q[63:32];
            `VLU_OFS_SCAL_LO:  s_axi_rdata <= scal_q[31:0];
            `VLU_OFS_SCAL_HI:  s_axi_rdata <= scal_q[63:32];
            `VLU_OFS_VADDR:    s_axi_rdata <= {23'h0, vaddr_q};
            `VLU_OFS_VDATA_LO: s_axi_rdata <= vsel[31:0];
            `VLU_OFS_VDATA_HI: s_axi_rdata <= vsel[63:32];
            default:           s_axi_rdata <= 32'h0;
         endcase
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

endmodule // vlu_top

// ==== sim/tb.sv ====
/*
 Bench: preloads the vector file, runs every opcode from a table and
 compares the destination's six elements with a shadow copy.
 Assumes the bus model and the bound checker.
*/
`include "vlu_map.vh"
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk_sys;
   logic        rst_b;
   wire  [7:0]  s_axi_awaddr, s_axi_araddr;
   wire  [31:0] s_axi_wdata, s_axi_rdata;
   wire  [3:0]  s_axi_wstrb;
   wire  [1:0]  s_axi_bresp, s_axi_rresp;
   wire         s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
   wire         s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   int          fail_count = 0;
   int          comparisons = 0;
   logic [63:0] sh [8][6];
   logic [63:0] scal = 64'hf0f0_0ff0_1234_5678;
   logic [63:0] mask = 64'h8000_0000_0000_0016;
   // Instruction word and element count; last entry is an unknown opcode
   logic [23:0] tbl [17] = '{24'hc05304, 24'hc04305, 24'hc31305, 24'hc32d03, 24'hc55604,
      24'hc54602, 24'hc79705, 24'hc79b04, 24'hc9ca05, 24'hc9c201, 24'hca1c05, 24'hca9205,
      24'hcccd05, 24'hccc504, 24'hce7705, 24'hc05300, 24'hd05305};

   vlu_top i_dut (.*);
   vlu_bus_model u_bus (.*);

   // System clock
   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end

   task automatic chk_val(input string nm, input logic [63:0] e, input logic [63:0] g);
      comparisons++;
      if (g !== e) begin
         fail_count++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic chk_resp(input string nm, input logic [1:0] e, input logic [1:0] g);
      comparisons++;
      if (g !== e) begin
         fail_count++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic w(input logic [7:0] a, input logic [31:0] d);
      logic [1:0] r;
      u_bus.wr(a, d, r);
      chk_resp("bresp", `VLU_RESP_OK, r);
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      logic [1:0] r;
      u_bus.rd(a, d, r);
      chk_resp("rresp", `VLU_RESP_OK, r);
   endtask

   task automatic put(input int v, input int n, input logic [63:0] d);
      w(`VLU_OFS_VADDR, 32'(v * 64 + n));
      w(`VLU_OFS_VDATA_LO, d[31:0]);
      w(`VLU_OFS_VDATA_HI, d[63:32]);
      sh[v][n] = d;
   endtask

   // Start one operation and update the shadow for elements below the count
   task automatic go(input logic [15:0] ins, input logic [7:0] c);
      logic [6:0]  o;
      logic [2:0]  i, j, k;
      logic [63:0] s, a, b, e;
      {o, i, j, k} = ins;
      w(`VLU_OFS_COUNT, {24'h0, c});
      u_bus.issue(o, i, j, k);
      s = (j == 3'h0) ? 64'h0 : scal;
      for (int n = 0; n < 6; n++) begin
         {a, b} = {sh[j][n], sh[k][n]};
         case (o[2:0])
            3'h0: e = s & b;
            3'h1: e = a & b;
            3'h2: e = s | b;
            3'h3: e = a | b;
            3'h4: e = s ^ b;
            3'h5: e = a ^ b;
            3'h6: e = mask[n] ? s : b;
            default: e = mask[n] ? a : b;
         endcase
         if (n < c && o[6:3] == 4'hc) sh[i][n] = e;
      end
   endtask

   // Busy is polled for at most 100 reads; a stuck unit falls through to the element checks
   task automatic fin(input logic [2:0] i);
      logic [31:0] lo, hi;
      lo = 32'h1;
      for (int t = 0; t < 100 && lo[0] !== 1'b0; t++) rd(`VLU_OFS_STATUS, lo);
      for (int n = 0; n < 6; n++) begin
         w(`VLU_OFS_VADDR, {23'h0, i, 6'(n)});
         rd(`VLU_OFS_VDATA_LO, lo);
         rd(`VLU_OFS_VDATA_HI, hi);
         chk_val("element", sh[i][n], {hi, lo});
      end
   endtask

   // Check sticky status, then clear it
   task automatic stat(input logic [31:0] e);
      logic [31:0] d;
      rd(`VLU_OFS_STATUS, d);
      chk_val("status", 64'(e), 64'(d));
      w(`VLU_OFS_STATUS, 32'h6);
   endtask

   task automatic results();
      $display("Comparisons %0d mismatches %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   // Watchdog, well above the few thousand cycles the run needs
   initial begin
      #200us;
      fail_count++;
      results();
   end

   // Main sequence
   initial begin
      logic [31:0] d;
      logic [1:0]  r;
      rst_b = 1'b0;
      repeat (10) @(posedge clk_sys);
      rst_b <= 1'b1;
      @(posedge clk_sys);
      rd(`VLU_OFS_COUNT, d);
      chk_val("count", 64'(`VLU_RST_COUNT), 64'(d));
      stat(32'h0);
      $display("Test reset values done");
      for (int v = 0; v < 8; v++)
         for (int n = 0; n < 6; n++)
            put(v, n, 64'h9e37_79b9_7f4a_7c15 * 64'(v * 6 + n + 1));
      w(`VLU_OFS_MASK_LO, mask[31:0]);
      w(`VLU_OFS_MASK_HI, mask[63:32]);
      w(`VLU_OFS_SCAL_LO, scal[31:0]);
      w(`VLU_OFS_SCAL_HI, scal[63:32]);
      for (int t = 0; t < 17; t++) begin
         go(tbl[t][23:8], tbl[t][7:0]);
         fin(tbl[t][16:14]);
      end
      stat(32'h2);
      $display("Test opcode table done");
      // Long count so the refused start and data writes land while busy
      go(16'hc313, 8'h28);
      u_bus.issue(7'h60, 3'h4, 3'h2, 3'h3);
      put(0, 5, 64'h0123_4567_89ab_cdef);
      fin(3'h4);
      stat(32'h4);
      rd(`VLU_OFS_INSTR, d);
      chk_val("instr", 64'hc313, 64'(d));
      $display("Test overrun done");
      // Partial strobes touch only their lanes; counts above the limit clamp
      u_bus.s_axi_wstrb <= 4'h2;
      w(`VLU_OFS_SCAL_LO, 32'haabb_ccdd);
      u_bus.s_axi_wstrb <= 4'hf;
      rd(`VLU_OFS_SCAL_LO, d);
      chk_val("scal_lo", 64'h1234_cc78, 64'(d));
      w(`VLU_OFS_COUNT, 32'h0000_0050);
      rd(`VLU_OFS_COUNT, d);
      chk_val("count", 64'h40, 64'(d));
      $display("Test strobes done");
      u_bus.wr(8'h40, 32'h1, r);
      chk_resp("bresp", `VLU_RESP_ERR, r);
      u_bus.rd(8'h40, d, r);
      chk_resp("rresp", `VLU_RESP_ERR, r);
      chk_val("rdata", 64'h0, 64'(d));
      $display("Test unmapped done");
      results();
   end
endmodule // tb

// ==== sim/vlu_bus_model.sv ====
/*
 Issue-side bus master: AXI4-Lite write and read tasks and an
 instruction issue task. Assumes the top's clock and 8-bit addresses.
*/
`include "vlu_map.vh"
module vlu_bus_model (
   input  logic        clk_sys,
   output logic [7:0]  s_axi_awaddr,
   output logic        s_axi_awvalid,
   input  logic        s_axi_awready,
   output logic [31:0] s_axi_wdata,
   output logic [3:0]  s_axi_wstrb,
   output logic        s_axi_wvalid,
   input  logic        s_axi_wready,
   input  logic [1:0]  s_axi_bresp,
   input  logic        s_axi_bvalid,
   output logic        s_axi_bready,
   output logic [7:0]  s_axi_araddr,
   output logic        s_axi_arvalid,
   input  logic        s_axi_arready,
   input  logic [31:0] s_axi_rdata,
   input  logic [1:0]  s_axi_rresp,
   input  logic        s_axi_rvalid,
   output logic        s_axi_rready
);
   timeunit 1ns;
   timeprecision 1ps;

   // Idle bus from time zero; whole-word strobes unless the bench changes them
   initial begin
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
      s_axi_wstrb = 4'hf;
   end

   // Each channel is held until its own ready is sampled
   task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      {s_axi_awaddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {a, d, 3'h7};
      do begin
         @(posedge clk_sys);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1);
      r = s_axi_bresp;
      s_axi_bready <= 1'b0;
      @(posedge clk_sys);
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'h3};
      do begin
         @(posedge clk_sys);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1);
      {d, r} = {s_axi_rdata, s_axi_rresp};
      s_axi_rready <= 1'b0;
      @(posedge clk_sys);
   endtask

   // Instruction word: opcode, then destination and source selects
   task automatic issue(input logic [6:0] o, input logic [2:0] i, j, k);
      logic [1:0] r;
      wr(`VLU_OFS_INSTR, {16'h0, o, i, j, k}, r);
   endtask
endmodule // vlu_bus_model

// ==== sim/vlu_checker_assertions.sv ====
/*
 Bus timing checks on the ports of the vector logical unit top.
 Assumes one clock and a synchronous active-low reset.
*/
`include "vlu_map.vh"
module vlu_checker #(
   parameter AW = 8
) (
   input logic        clk_sys,
   input logic        rst_b,
   input logic        s_axi_awvalid,
   input logic        s_axi_awready,
   input logic        s_axi_wvalid,
   input logic        s_axi_wready,
   input logic [1:0]  s_axi_bresp,
   input logic        s_axi_bvalid,
   input logic        s_axi_bready,
   input logic        s_axi_arvalid,
   input logic        s_axi_arready,
   input logic [31:0] s_axi_rdata,
   input logic [1:0]  s_axi_rresp,
   input logic        s_axi_rvalid,
   input logic        s_axi_rready
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking dc @(posedge clk_sys);
   endclocking
   default disable iff (!rst_b);

   // Answers come a fixed time after the request is taken; the write is
   // performed one edge after both halves are held, so bvalid needs two edges
   a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
      && s_axi_wready |=> ##1 s_axi_bvalid) else $error("write answer late");
   a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer late");
   // Answers stand until taken, then drop
   a_bresp_stands: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
      && $stable(s_axi_bresp)) else $error("write answer dropped");
   a_rdata_stands: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
      && $stable(s_axi_rdata) && $stable(s_axi_rresp)) else $error("read data moved");
   a_bvalid_clears: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
      else $error("write answer repeated");
   a_rvalid_clears: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
      else $error("read answer repeated");
   // Only one read in flight, so no address is taken while data waits
   a_ar_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read address taken while busy");
   // Refused reads carry no data
   a_err_zero: assert property (s_axi_rvalid && s_axi_rresp == `VLU_RESP_ERR
      |-> s_axi_rdata == 32'h0) else $error("refused read with data");
   a_bresp_legal: assert property (s_axi_bvalid |-> s_axi_bresp == `VLU_RESP_OK
      || s_axi_bresp == `VLU_RESP_ERR) else $error("odd write response");

   c_write_err: cover property (s_axi_bvalid && s_axi_bresp == `VLU_RESP_ERR);
   c_read_err: cover property (s_axi_rvalid && s_axi_rresp == `VLU_RESP_ERR);
   c_read_ok: cover property (s_axi_rvalid && s_axi_rready);
endmodule // vlu_checker

bind vlu_top vlu_checker #(.AW(AW)) u_chk (.*);
